/* core/edge_detector.v */
// Purpose: selectable edge detect on one synchronous input pin
// Assumes: pin already synchronous to clock
// Notes: pulse one cycle on the chosen edge
`default_nettype none
module edge_detector
(
  // clock and reset
  input  wire clock,
  input  wire rst,
  // pin and selection
  input  wire pin,
  input  wire falling,
  // result
  output wire hit
);
  reg last;
  reg armed;

  // armed keeps the first cycle after reset quiet, whatever the pin level
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      last  <= 1'b1;
      armed <= 1'b0;
    end
    else
    begin
      last  <= pin;
      armed <= 1'b1;
    end
  end

  assign hit = armed & (falling ? (last & ~pin) : (~last & pin));
endmodule // edge_detector
`default_nettype wire

/* core/ext_irq_and_interval_timer.v */
// Purpose: external interrupt pins, tone output and interval timer
// Assumes: crystal clock is a one-cycle enable pulse in the system clock
// Notes: pending requests are cleared by the core acknowledge inputs
`include "irq_timer_regs.vh"
`default_nettype none
module ext_irq_and_interval_timer
(
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // crystal tick, one cycle per crystal period
  input  wire       xtal_tick,
  // nibble write port
  input  wire       port_write,
  input  wire [3:0] port_addr,
  input  wire [3:0] port_data,
  // external pins
  input  wire       high_prio_irq_pin,
  input  wire       tone_capable_irq_pin_in,
  output reg        tone_capable_irq_pin_out,
  output reg        tone_capable_irq_pin_oe,
  // tone divide select, high picks divide-by-16
  input  wire       tone_div16,
  // core side
  input  wire       global_irq_enable,
  input  wire       instr_done,
  input  wire [7:0] pending_clear,
  output reg  [7:0] pending,
  output reg        irq_entry
);
  ////////////////////////////////////////////////////////////////////////
  reg        high_enable;
  reg        tone_enable;
  reg        high_falling;
  reg        tone_falling;
  reg [1:0]  tone_function;
  reg        slow_chosen;
  reg [2:0]  slow_sel;
  reg [2:0]  fast_sel;
  reg        fast_enable;
  reg        prescaler_hold;
  reg [`PRESCALER_STAGES-1:0] prescaler;
  reg [`PRESCALER_STAGES-1:0] next_prescaler;
  reg        tone_div_reg;
  wire       high_hit;
  wire       tone_hit;
  wire [3:0] pin_code;
  wire [3:0] rate_code;
  wire       pin_wr;
  wire       rate_wr;

  assign pin_wr    = port_write && port_addr == `PIN_CTRL_ADDR;   // [RULE10]
  assign rate_wr   = port_write && port_addr == `RATE_CTRL_ADDR;
  assign pin_code  = port_data;
  assign rate_code = port_data;

  ////////////////////////////////////////////////////////////////////////
  // pin control nibble
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      high_enable   <= 1'b1;                                     // [RULE5]
      tone_enable   <= 1'b1;
      high_falling  <= 1'b1;
      tone_falling  <= 1'b1;
      tone_function <= `TONE_FN_IRQ;
    end
    else if (pin_wr)
    begin
      case (pin_code)
        4'hf, 4'he, 4'hd, 4'hc:
        begin
          // both pins enabled, edges from bits 1 and 0
          high_enable   <= 1'b1;                                 // [RULE6]
          tone_enable   <= 1'b1;
          high_falling  <= pin_code[1];
          tone_falling  <= pin_code[0];
          tone_function <= `TONE_FN_IRQ;
        end
        4'hb, 4'h7, 4'h3:
        begin
          // independent masks; edges go back to falling
          high_enable   <= pin_code[3];                          // [RULE7]
          tone_enable   <= pin_code[2];                          // [RULE4]
          high_falling  <= 1'b1;
          tone_falling  <= 1'b1;
          tone_function <= `TONE_FN_IRQ;
        end
        4'h6, 4'h5, 4'h4:
          // undefined codes only mask the tone pin
          tone_enable <= 1'b0;                                   // [RULE21]
        default:
        begin
          // output modes keep both edges untouched
          high_enable   <= pin_code[3];                          // [RULE8]
          tone_enable   <= 1'b0;
          tone_function <= pin_code[1:0];
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rate control nibble
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      prescaler_hold <= 1'b1;                                    // [RULE13]
      fast_enable    <= 1'b0;                                    // [RULE17]
      fast_sel       <= 3'h0;
      slow_sel       <= `RATE_SLOW_DEFAULT;
      slow_chosen    <= 1'b0;
    end
    else if (rate_wr)
    begin
      if (rate_code == `RATE_CTRL_RESET)
        prescaler_hold <= 1'b1;                                  // [RULE13]
      else if (rate_code == `RATE_DISABLE_FAST)
      begin
        prescaler_hold <= 1'b0;
        fast_enable    <= 1'b0;                                  // [RULE16]
      end
      else if (rate_code[3] && rate_code != `RATE_RESERVED)
      begin
        prescaler_hold <= 1'b0;
        fast_enable    <= 1'b1;                                  // [RULE16]
        fast_sel       <= rate_code[2:0] - 3'h1;
        if (!slow_chosen)
          slow_sel <= `RATE_SLOW_DEFAULT;                        // [RULE18]
      end
      else if (!rate_code[3])
      begin
        prescaler_hold <= 1'b0;
        slow_sel       <= rate_code[2:0];                        // [RULE14]
        slow_chosen    <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler: slow tap 2^(8+7-code), fast tap 2^(3+2*(4-idx))
  always @*
  begin
    next_prescaler = prescaler + {{(`PRESCALER_STAGES-1){1'b0}}, 1'b1};
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      prescaler <= {`PRESCALER_STAGES{1'b0}};
    else if (prescaler_hold)
      prescaler <= {`PRESCALER_STAGES{1'b0}};                    // [RULE13]
    else if (xtal_tick)
      prescaler <= next_prescaler;                               // [RULE11]
  end

  // a tap wraps to zero when all bits below it are ones before the tick
  function tap_wrap;
    input [`PRESCALER_STAGES-1:0] value;
    input integer                  bits;
    integer i;
    begin
      tap_wrap = 1'b1;
      for (i = 0; i < `PRESCALER_STAGES; i = i + 1)
        if (i < bits && !value[i])
          tap_wrap = 1'b0;
    end
  endfunction

  wire slow_event;
  wire fast_event;
  assign slow_event = xtal_tick && !prescaler_hold &&
                      tap_wrap(prescaler, 15 - slow_sel);        // [RULE14] [RULE15]
  // fast_sel 4..0 stand for codes D..9
  assign fast_event = xtal_tick && !prescaler_hold && fast_enable &&
                      tap_wrap(prescaler, 11 - 2 * fast_sel);    // [RULE16]

  ////////////////////////////////////////////////////////////////////////
  edge_detector high_edge
  (
    .clock   (clock),
    .rst     (rst),
    .pin     (high_prio_irq_pin),
    .falling (high_falling),
    .hit     (high_hit)
  );

  edge_detector tone_edge
  (
    .clock   (clock),
    .rst     (rst),
    .pin     (tone_capable_irq_pin_in),
    .falling (tone_falling),
    .hit     (tone_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // pending register; a new request wins over a same-cycle clear
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      pending <= 8'h00;
    else
    begin
      pending <= (pending & ~pending_clear) |
                 {high_hit && high_enable,                       // [RULE1] [RULE19]
                  fast_event,                                    // [RULE12]
                  slow_event,
                  2'b00,
                  tone_hit && tone_enable && tone_function == `TONE_FN_IRQ,
                  2'b00};
    end
  end

  // sampled at instruction boundaries only
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_entry <= 1'b0;
    else
      irq_entry <= instr_done && global_irq_enable &&            // [RULE2]
                   (pending != 8'h00);                           // [RULE3]
  end

  ////////////////////////////////////////////////////////////////////////
  // tone output; select registered one clock, so a mid-period change switches taps at once
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      tone_div_reg <= 1'b0;                                      // [RULE20]
    else
      tone_div_reg <= tone_div16;
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      tone_capable_irq_pin_out <= 1'b0;
      tone_capable_irq_pin_oe  <= 1'b0;
    end
    else
    begin
      tone_capable_irq_pin_oe <= tone_function != `TONE_FN_IRQ;  // [RULE8]
      case (tone_function)
        `TONE_FN_HIGH: tone_capable_irq_pin_out <= 1'b1;
        `TONE_FN_LOW:  tone_capable_irq_pin_out <= 1'b0;
        // square wave period 8 or 16 crystal cycles
        `TONE_FN_BUZZ: tone_capable_irq_pin_out <= tone_div_reg ?
                                                   prescaler[3] :
                                                   prescaler[2]; // [RULE9]
        default:       tone_capable_irq_pin_out <= 1'b0;
      endcase
    end
  end
endmodule // ext_irq_and_interval_timer
`default_nettype wire

/* core/irq_timer_regs.vh */
// Purpose: constants for the external interrupt and interval timer block
// Assumes: 4-bit nibble writes at documented port addresses
// Notes on behaviour
// RULE1: selected edge on an enabled pin latches a pending request.
// RULE2: core finishes its instruction before testing pending requests.
// RULE3: entry starts only if a request pends and global enable is set.
// RULE4: each external pin masks on its own, others unaffected.
// RULE5: reset loads pin control with F: both pins enabled, falling edge.
// RULE6: codes F..C enable both pins; bit1 high-prio edge, bit0 tone pin.
// RULE7: codes B, 7, 3 mask tone pin, high-prio pin, or both; falling.
// RULE8: bit 2 clear, bits 1,0 not both set: tone pin output, masked, bits1:0 pick level.
// RULE9: tone output toggles at crystal divided by 8 or 16.
// RULE10: all pin functions come from one nibble at port 6.
// RULE11: interval timer is a 15-stage crystal-clocked divider, two muxes.
// RULE12: slow interval raises level 5, fast interval level 6.
// RULE13: timer control powers up at F; F resets and holds prescaler.
// RULE14: codes 7..0 at port 15 pick slow rate 2^8..2^15; 8 reserved.
// RULE15: slow interval has no own mask; only prescaler reset stops it.
// RULE16: codes D..9 pick fast rate 2^3..2^11; E disables fast only.
// RULE17: fast tap mux powers up disabled.
// RULE18: fast rate set with no slow rate chosen gives slow 128 Hz.
// RULE19: high-prio pin raises level 7, tone pin level 2.
// RULE20: tone divide select is an outside input, reset to divide-by-8.
// RULE21: pin codes 4, 5, 6 mask tone pin, keep edge and function.
`ifndef IRQ_TIMER_REGS_VH
`define IRQ_TIMER_REGS_VH
`define PIN_CTRL_ADDR      4'h6
`define RATE_CTRL_ADDR     4'hf
`define PIN_CTRL_RESET     4'hf
`define RATE_CTRL_RESET    4'hf
`define RATE_DISABLE_FAST  4'he
`define RATE_RESERVED      4'h8
`define RATE_SLOW_DEFAULT  3'h7
`define PRESCALER_STAGES   15
`define SLOW_BASE_STAGE    7
`define XTAL_FREQ_HZ       32768
`define CLOCK_FREQ_HZ      10000000
`define TONE_FN_HIGH       2'h2
`define TONE_FN_LOW        2'h1
`define TONE_FN_BUZZ       2'h0
`define TONE_FN_IRQ        2'h3
`endif

/* verification/ext_pins_model.sv */
// Purpose: crystal and external pin partner of the block
// Assumes: tone pin pulled up, bench level wins when block is off it
// Notes: one crystal tick every second clock
`default_nettype none
module ext_pins_model
(
  // bench side
  input  wire logic clock,
  input  wire logic hp_level,
  input  wire logic tone_level,
  // block side
  input  wire logic tone_capable_irq_pin_out,
  input  wire logic tone_capable_irq_pin_oe,
  output var  logic xtal_tick,
  output wire logic high_prio_irq_pin,
  output wire logic tone_capable_irq_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
    xtal_tick = 1'b0;
  always @(posedge clock)
    xtal_tick <= #1 !xtal_tick;
  assign high_prio_irq_pin = hp_level;
  // block owns the wire while it drives
  assign tone_capable_irq_pin_in = tone_capable_irq_pin_oe ?
    tone_capable_irq_pin_out : tone_level;
endmodule // ext_pins_model
`default_nettype wire

/* verification/irq_timer_props.sv */
// Purpose: port assertions of the interrupt and interval timer
// Assumes: a nibble write acts from the next edge
// Notes: two cycles of slack around mode changes
`default_nettype none
module irq_timer_props
(
  // all block ports
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       xtal_tick,
  input wire logic       port_write,
  input wire logic [3:0] port_addr,
  input wire logic [3:0] port_data,
  input wire logic       high_prio_irq_pin,
  input wire logic       tone_capable_irq_pin_in,
  input wire logic       tone_capable_irq_pin_out,
  input wire logic       tone_capable_irq_pin_oe,
  input wire logic       tone_div16,
  input wire logic       global_irq_enable,
  input wire logic       instr_done,
  input wire logic [7:0] pending_clear,
  input wire logic [7:0] pending,
  input wire logic       irq_entry
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       held;
  logic [3:0] pin_code;
  wire        ready  = instr_done && global_irq_enable && |pending;
  wire        hp_off = pin_code == 4'h7 || pin_code == 4'h3;
  wire        oe     = tone_capable_irq_pin_oe;
  always @(posedge clock or posedge rst)
    if (rst)
      {held, pin_code} <= 5'h1f;
    else if (port_write && port_addr == 4'hf && port_data != 4'h8)
      held <= port_data == 4'hf;
    else if (port_write && port_addr == 4'h6)
      pin_code <= port_data;
  sequence pin_write(code);
    port_write && port_addr == 4'h6 && port_data == code;
  endsequence
  entry_fire_a: assert property (ready |=> irq_entry)
    else $error("entry missing");
  entry_cause_a: assert property (irq_entry |-> $past(ready))
    else $error("entry without cause");
  pending_hold_a: assert property (pending[7] && !pending_clear[7]
    |=> pending[7]) else $error("request lost");
  unused_levels_a: assert property ((pending & 8'h1b) == 8'h00)
    else $error("unused level set");
  held_quiet_a: assert property (held && $past(held, 2)
    |-> !$rose(pending[5]) && !$rose(pending[6])) else $error("held tick");
  tone_masked_a: assert property (oe && $past(oe, 2)
    |-> !$rose(pending[2])) else $error("driven pin raised request");
  hp_masked_a: assert property (hp_off && $past(hp_off, 2)
    |-> !$rose(pending[7])) else $error("masked pin raised request");
  drive_high_a: assert property (pin_write(4'ha)
    |=> ##1 (oe && tone_capable_irq_pin_out))
    else $error("high drive missing");
endmodule // irq_timer_props
bind ext_irq_and_interval_timer irq_timer_props u_irq_timer_props (.*);
`default_nettype wire

/* verification/tb_top.sv */
// Purpose: self-checking bench of the interrupt and interval timer
// Assumes: crystal tick every second clock
// Notes: rate rows hold code, pending bit and ticks per period
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock, rst, hp_level, tone_level, xtal_tick, port_write, t;
  logic       high_prio_irq_pin, tone_capable_irq_pin_in, tone_div16;
  logic       tone_capable_irq_pin_out, tone_capable_irq_pin_oe;
  logic       global_irq_enable, instr_done, irq_entry;
  logic [3:0] port_addr, port_data;
  logic [7:0] pending_clear, pending;
  wire  [1:0] drive = {tone_capable_irq_pin_oe, tone_capable_irq_pin_out};
  int         fail_count, n_tests, ticks, c;
  logic [15:0] pins[8] = '{16'hf384, 16'he284, 16'hd184, 16'hc084,
    16'hb380, 16'h7304, 16'h3300, 16'he100};
  logic [23:0] rates[10] = '{24'hd5_0100, 24'hd6_0008, 24'hc6_0020,
    24'hb6_0080, 24'ha6_0200, 24'h96_0800, 24'he5_0100, 24'h65_0200,
    24'h85_0200, 24'h55_0400};
  ext_irq_and_interval_timer u_ext_irq_and_interval_timer (.*);
  ext_pins_model u_ext_pins_model (.*);
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
    ticks <= ticks + xtal_tick;
  ////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, d);
    port_write = 1'b1;
    port_addr = a;
    port_data = d;
    step(1);
    port_write = 1'b0;
    step(1);
  endtask
  task automatic clr;
    pending_clear = 8'hff;
    step(1);
    pending_clear = 8'h00;
    step(1);
  endtask
  task automatic edges(input logic hf, tf);
    hp_level = hf;
    tone_level = tf;
    step(3);
    clr();
    hp_level = !hf;
    tone_level = !tf;
    step(3);
  endtask
  task automatic hit(input int b);
    for (c = 0; c < 9000 && pending[b] !== 1'b1; c++)
      step(1);
    if (c == 9000)
    begin
      fail_count++;
      stop_test();
    end
  endtask
  // first period after a change may be short, so it is thrown away
  task automatic gap(input int b, input int e);
    int s;
    clr();
    hit(b);
    clr();
    hit(b);
    s = ticks;
    clr();
    hit(b);
    check("interval", e, ticks - s);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    {port_write, tone_div16, global_irq_enable, instr_done} = 4'h0;
    {hp_level, tone_level, port_addr, port_data} = 10'h300;
    pending_clear = 8'h00;
    step(16);
    rst = 1'b0;
    foreach (pins[i])
    begin
      wr(4'h6, pins[i][15:12]);
      edges(pins[i][9], pins[i][8]);
      check("pins", pins[i][7:0], pending);
    end
    wr(4'h6, 4'hc);
    wr(4'h6, 4'ha);
    check("drive", 2'b11, drive);
    edges(1'b0, 1'b0);
    check("kept edge", 8'h80, pending);
    wr(4'h6, 4'h9);
    check("drive", 2'b10, drive);
    wr(4'h6, 4'hc);
    wr(4'h6, 4'h5);
    edges(1'b0, 1'b0);
    check("undefined", 2'b00, {drive[1], pending[2]});
    wr(4'h6, 4'hf);
    wr(4'h3, 4'h3);
    edges(1'b1, 1'b1);
    check("unmapped", 8'h84, pending);
    instr_done = 1'b1;
    step(1);
    check("entry", 1'b0, irq_entry);
    global_irq_enable = 1'b1;
    step(1);
    instr_done = 1'b0;
    check("entry", 1'b1, irq_entry);
    // leave rising edges, a masked high pin and a driven tone pin
    wr(4'h6, 4'hc);
    wr(4'h6, 4'h0);
    rst = 1'b1;
    step(2);
    check("reset", 10'h000, {drive[1], irq_entry, pending});
    rst = 1'b0;
    edges(1'b1, 1'b1);
    check("reset pins", 8'h84, pending);
    foreach (rates[i])
    begin
      wr(4'hf, rates[i][23:20]);
      gap(rates[i][19:16], rates[i][15:0]);
    end
    check("fast off", 1'b0, pending[6]);
    wr(4'h6, 4'h8);
    for (int d = 0; d < 2; d++)
    begin
      tone_div16 = d[0];
      step(4);
      c = 0;
      for (int k = 0; k < 128; k++)
      begin
        t = tone_capable_irq_pin_out;
        step(1);
        c += (tone_capable_irq_pin_out !== t);
      end
      check("tone", 16 >> d, c);
    end
    wr(4'hf, 4'hf);
    clr();
    step(2100);
    check("held", 8'h00, pending);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
